//--- rtl/safety_stop_pkg.sv
package safety_stop_pkg;

  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;
  localparam int CODE_WIDTH = 8;
  localparam int TERM_COUNT = 3;
  localparam int EVENT_COUNT = 4;

  // Register byte addresses
  localparam logic [ADDR_WIDTH-1:0] ADDR_SEL_A = 8'h00;
  localparam logic [ADDR_WIDTH-1:0] ADDR_SEL_B = 8'h04;
  localparam logic [ADDR_WIDTH-1:0] ADDR_SEL_C = 8'h08;
  localparam logic [ADDR_WIDTH-1:0] ADDR_STATE = 8'h0C;
  localparam logic [ADDR_WIDTH-1:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [ADDR_WIDTH-1:0] ADDR_IRQ_CLEAR = 8'h14;
  localparam logic [ADDR_WIDTH-1:0] ADDR_IRQ_ENABLE = 8'h18;

  // Output terminal function codes
  localparam logic [CODE_WIDTH-1:0] CODE_RUN_POS = 8'h00;
  localparam logic [CODE_WIDTH-1:0] CODE_RUN_NEG = 8'h64;
  localparam logic [CODE_WIDTH-1:0] CODE_STOP_POS = 8'h50;
  localparam logic [CODE_WIDTH-1:0] CODE_STOP_NEG = 8'hB4;
  localparam logic [CODE_WIDTH-1:0] CODE_HEALTH_POS = 8'h51;
  localparam logic [CODE_WIDTH-1:0] CODE_HEALTH_NEG = 8'hB5;

  // Reset values of the selection registers and the interrupt enable register
  localparam logic [CODE_WIDTH-1:0] SEL_A_RESET = CODE_RUN_POS;
  localparam logic [CODE_WIDTH-1:0] SEL_B_RESET = CODE_RUN_POS;
  localparam logic [CODE_WIDTH-1:0] SEL_C_RESET = CODE_RUN_POS;
  localparam logic [EVENT_COUNT-1:0] IRQ_ENABLE_RESET = 4'h0;

  // Event bits of the interrupt registers
  localparam int EV_STOP = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_MISMATCH = 2;
  localparam int EV_POWER_LOSS = 3;

  // Fields of the live state register
  localparam int ST_STATE_LSB = 0;
  localparam int ST_DISPLAY_LSB = 4;
  localparam int ST_DRIVE_BIT = 8;
  localparam int ST_STOP_MON_BIT = 9;
  localparam int ST_HEALTH_BIT = 10;
  localparam int ST_INPUT_A_BIT = 11;
  localparam int ST_INPUT_B_BIT = 12;
  localparam int ST_TERM_LSB = 16;

  typedef enum logic [2:0] {
    ST_POWER_OFF = 3'b000,
    ST_ENABLED = 3'b001,
    ST_STOPPED = 3'b010,
    ST_FAULT = 3'b011,
    ST_MISMATCH = 3'b100
  } safety_state_type;

  typedef enum logic [1:0] {
    DISP_NONE = 2'b00,
    DISP_STOP_ACTIVE = 2'b01,
    DISP_FAULT_A = 2'b10,
    DISP_FAULT_B = 2'b11
  } display_type;

endpackage

//--- rtl/term_map_if.sv
interface term_map_if;
  import safety_stop_pkg::*;
  logic stop_mon;
  logic health;
  logic running;
  logic [TERM_COUNT-1:0][CODE_WIDTH-1:0] sel;
  logic [TERM_COUNT-1:0] term_on;

  modport source (
    output stop_mon,
    output health,
    output running,
    output sel,
    input term_on
  );

  modport mapper (
    input stop_mon,
    input health,
    input running,
    input sel,
    output term_on
  );
endinterface

//--- rtl/terminal_mapper.sv
module terminal_mapper
  import safety_stop_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  term_map_if.mapper map
);

  // Unknown codes leave the transistor off, the safe reading
  function automatic logic term_level(
    input logic [CODE_WIDTH-1:0] code,
    input logic stop,
    input logic health,
    input logic running
  );
    case (code)
      CODE_RUN_POS: term_level = running;
      CODE_RUN_NEG: term_level = !running;
      CODE_STOP_POS: term_level = stop;
      CODE_STOP_NEG: term_level = !stop;
      CODE_HEALTH_POS: term_level = health;
      CODE_HEALTH_NEG: term_level = !health;
      default: term_level = 1'b0;
    endcase
  endfunction

  genvar i;
  generate
    for (i = 0; i < TERM_COUNT; i++) begin : g_term
      wire logic level_next;
      logic level_reg;
      assign level_next = term_level(map.sel[i], map.stop_mon, map.health, map.running);
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          level_reg <= 1'b0;
        end else begin
          level_reg <= level_next;
        end
      end
      assign map.term_on[i] = level_reg;
    end
  endgenerate

endmodule

//--- rtl/dual_channel_safety_stop.sv
// The register offsets and the APB interface to the registers were chosen for this implementation.
module dual_channel_safety_stop
  import safety_stop_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic power_present,
  input wire logic stop_input_a,
  input wire logic stop_input_b,
  input wire logic fault_a_detect,
  input wire logic fault_b_detect,
  input wire logic drive_running,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [DATA_WIDTH-1:0] pwdata,
  output logic [DATA_WIDTH-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic drive_enable,
  output logic monitor_terminal_on,
  output logic run_terminal_on,
  output logic aux_terminal_b_on,
  output logic aux_terminal_c_on,
  output display_type stop_display,
  output logic irq
);

  // Stop inputs are high while the channel is shorted to stop_common
  wire logic open_a;
  wire logic open_b;
  wire logic any_fault;
  wire logic both_open;
  wire logic both_short;
  wire logic one_open;

  assign open_a = !stop_input_a;
  assign open_b = !stop_input_b;
  assign any_fault = fault_a_detect || fault_b_detect;
  assign both_open = open_a && open_b;
  assign both_short = !open_a && !open_b;
  assign one_open = open_a != open_b;

  safety_state_type state_reg;
  safety_state_type state_next;

  // Mismatch outranks fault: fault status does not apply then
  always_comb begin
    if (!power_present) begin
      state_next = ST_POWER_OFF;
    end else if (one_open) begin
      state_next = ST_MISMATCH;
    end else if (any_fault) begin
      state_next = ST_FAULT;
    end else if (both_short) begin
      state_next = ST_ENABLED;
    end else begin
      state_next = ST_STOPPED;
    end
  end

  logic drive_next;
  logic stop_mon_next;
  logic health_next;
  display_type display_next;

  always_comb begin
    drive_next = 1'b0;
    stop_mon_next = 1'b0;
    health_next = 1'b0;
    display_next = DISP_NONE;
    case (state_next)
      ST_POWER_OFF: begin
        drive_next = 1'b0;
      end
      ST_ENABLED: begin
        drive_next = 1'b1;
        health_next = 1'b1;
      end
      ST_STOPPED: begin
        stop_mon_next = 1'b1;
        health_next = 1'b1;
        display_next = DISP_STOP_ACTIVE;
      end
      ST_FAULT: begin
        display_next = fault_a_detect ? DISP_FAULT_A : DISP_FAULT_B;
      end
      ST_MISMATCH: begin
        health_next = 1'b0;
      end
      default: begin
        drive_next = 1'b0;
      end
    endcase
  end

  logic drive_reg;
  logic stop_mon_reg;
  logic health_reg;
  display_type display_reg;

  // Safety outputs come from flops so that a glitch on the inputs cannot reach those pins; pslverr is decoded directly from the APB inputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_POWER_OFF;
      drive_reg <= 1'b0;
      stop_mon_reg <= 1'b0;
      health_reg <= 1'b0;
      display_reg <= DISP_NONE;
    end else begin
      state_reg <= state_next;
      drive_reg <= drive_next;
      stop_mon_reg <= stop_mon_next;
      health_reg <= health_next;
      display_reg <= display_next;
    end
  end

  assign drive_enable = drive_reg;
  assign monitor_terminal_on = stop_mon_reg;
  assign stop_display = display_reg;

  // APB slave, zero wait states
  function automatic logic addr_hit(
    input logic [ADDR_WIDTH-1:0] addr,
    input logic [ADDR_WIDTH-1:0] target
  );
    addr_hit = addr == target;
  endfunction

  wire logic access;
  wire logic setup_rd;
  wire logic wr_en;
  wire logic hit_sel_a;
  wire logic hit_sel_b;
  wire logic hit_sel_c;
  wire logic hit_state;
  wire logic hit_irq_status;
  wire logic hit_irq_clear;
  wire logic hit_irq_enable;
  wire logic mapped;

  assign access = psel && penable;
  assign setup_rd = psel && !penable && !pwrite;
  assign wr_en = access && pwrite;
  assign hit_sel_a = addr_hit(paddr, ADDR_SEL_A);
  assign hit_sel_b = addr_hit(paddr, ADDR_SEL_B);
  assign hit_sel_c = addr_hit(paddr, ADDR_SEL_C);
  assign hit_state = addr_hit(paddr, ADDR_STATE);
  assign hit_irq_status = addr_hit(paddr, ADDR_IRQ_STATUS);
  assign hit_irq_clear = addr_hit(paddr, ADDR_IRQ_CLEAR);
  assign hit_irq_enable = addr_hit(paddr, ADDR_IRQ_ENABLE);
  assign mapped = hit_sel_a || hit_sel_b || hit_sel_c || hit_state ||
                  hit_irq_status || hit_irq_clear || hit_irq_enable;

  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  logic [CODE_WIDTH-1:0] sel_a_reg;
  logic [CODE_WIDTH-1:0] sel_b_reg;
  logic [CODE_WIDTH-1:0] sel_c_reg;

  // Wrong code is stored as written; the terminal then stays off
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_a_reg <= SEL_A_RESET;
      sel_b_reg <= SEL_B_RESET;
      sel_c_reg <= SEL_C_RESET;
    end else if (wr_en) begin
      if (hit_sel_a) begin
        sel_a_reg <= pwdata[CODE_WIDTH-1:0];
      end
      if (hit_sel_b) begin
        sel_b_reg <= pwdata[CODE_WIDTH-1:0];
      end
      if (hit_sel_c) begin
        sel_c_reg <= pwdata[CODE_WIDTH-1:0];
      end
    end
  end

  // Events and interrupt
  wire logic [EVENT_COUNT-1:0] events;
  wire logic [EVENT_COUNT-1:0] clear_mask;
  logic [EVENT_COUNT-1:0] irq_status_reg;
  logic [EVENT_COUNT-1:0] irq_enable_reg;

  assign events[EV_STOP] = state_next == ST_STOPPED && state_reg != ST_STOPPED;
  assign events[EV_FAULT] = state_next == ST_FAULT && state_reg != ST_FAULT;
  assign events[EV_MISMATCH] = state_next == ST_MISMATCH && state_reg != ST_MISMATCH;
  assign events[EV_POWER_LOSS] = state_next == ST_POWER_OFF && state_reg != ST_POWER_OFF;
  assign clear_mask = (wr_en && hit_irq_clear) ? pwdata[EVENT_COUNT-1:0] : '0;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= '0;
      irq_enable_reg <= IRQ_ENABLE_RESET;
    end else begin
      irq_status_reg <= (irq_status_reg & ~clear_mask) | events;
      if (wr_en && hit_irq_enable) begin
        irq_enable_reg <= pwdata[EVENT_COUNT-1:0];
      end
    end
  end

  assign irq = |(irq_status_reg & irq_enable_reg);

  // Terminal mapping
  term_map_if map_bus ();

  assign map_bus.stop_mon = stop_mon_reg;
  assign map_bus.health = health_reg;
  assign map_bus.running = drive_running && drive_reg;
  assign map_bus.sel[0] = sel_a_reg;
  assign map_bus.sel[1] = sel_b_reg;
  assign map_bus.sel[2] = sel_c_reg;

  terminal_mapper mapper_inst (
    .clock(clock),
    .rst_n(rst_n),
    .map(map_bus.mapper)
  );

  assign run_terminal_on = map_bus.term_on[0];
  assign aux_terminal_b_on = map_bus.term_on[1];
  assign aux_terminal_c_on = map_bus.term_on[2];

  // Read path
  wire logic [DATA_WIDTH-1:0] state_word;
  wire logic [DATA_WIDTH-1:0] read_mux;

  assign state_word = (DATA_WIDTH'(state_reg) << ST_STATE_LSB) |
                      (DATA_WIDTH'(display_reg) << ST_DISPLAY_LSB) |
                      (DATA_WIDTH'(drive_reg) << ST_DRIVE_BIT) |
                      (DATA_WIDTH'(stop_mon_reg) << ST_STOP_MON_BIT) |
                      (DATA_WIDTH'(health_reg) << ST_HEALTH_BIT) |
                      (DATA_WIDTH'(stop_input_a) << ST_INPUT_A_BIT) |
                      (DATA_WIDTH'(stop_input_b) << ST_INPUT_B_BIT) |
                      (DATA_WIDTH'(map_bus.term_on) << ST_TERM_LSB);

  // Clear register is write-only and reads as zero
  assign read_mux = hit_sel_a ? DATA_WIDTH'(sel_a_reg) :
                    hit_sel_b ? DATA_WIDTH'(sel_b_reg) :
                    hit_sel_c ? DATA_WIDTH'(sel_c_reg) :
                    hit_state ? state_word :
                    hit_irq_status ? DATA_WIDTH'(irq_status_reg) :
                    hit_irq_enable ? DATA_WIDTH'(irq_enable_reg) :
                    '0;

  // Captured in setup so the data stands through the access cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (setup_rd) begin
      prdata <= read_mux;
    end
  end

  // Checks
  open_blocks_drive_a: assert property (@(posedge clock) disable iff (!rst_n)
    (open_a || open_b) |=> !drive_enable)
    else $error("drive enabled with a stop channel open");

  enable_cause_a: assert property (@(posedge clock) disable iff (!rst_n)
    (power_present && both_short && !any_fault) |=>
      (drive_enable && !monitor_terminal_on && health_reg))
    else $error("drive not enabled with all conditions met");

  stop_mon_cause_a: assert property (@(posedge clock) disable iff (!rst_n)
    monitor_terminal_on |-> (!drive_enable && health_reg && $past(both_open)))
    else $error("stop monitor on without a clean stop");

  health_fault_a: assert property (@(posedge clock) disable iff (!rst_n)
    (power_present && any_fault) |=> !health_reg)
    else $error("health on during internal fault");

  both_open_a: assert property (@(posedge clock) disable iff (!rst_n)
    (power_present && both_open && !any_fault) |=>
      (!drive_enable && monitor_terminal_on && health_reg &&
       stop_display == DISP_STOP_ACTIVE))
    else $error("wrong outputs with both channels open");

  fault_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    (power_present && any_fault && !one_open) |=>
      (!drive_enable && !monitor_terminal_on && !health_reg &&
       (stop_display == DISP_FAULT_A || stop_display == DISP_FAULT_B)))
    else $error("wrong outputs at internal fault");

  one_open_a: assert property (@(posedge clock) disable iff (!rst_n)
    (power_present && one_open) |=>
      (!drive_enable && !monitor_terminal_on && !health_reg))
    else $error("wrong outputs with one channel open");

  map_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
    (sel_b_reg == CODE_STOP_POS && $stable(sel_b_reg)) |->
      ##1 (aux_terminal_b_on == $past(stop_mon_reg)))
    else $error("stop monitor not mapped to terminal b");

  map_health_a: assert property (@(posedge clock) disable iff (!rst_n)
    (sel_c_reg == CODE_HEALTH_NEG) |=> (aux_terminal_c_on == !$past(health_reg)))
    else $error("negative health not mapped to terminal c");

  run_health_a: assert property (@(posedge clock) disable iff (!rst_n)
    (sel_a_reg == CODE_HEALTH_POS && power_present && any_fault) |=> ##1 !run_terminal_on)
    else $error("run terminal stays on at fault");

  power_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    !power_present |=> (!drive_enable && !monitor_terminal_on && !health_reg))
    else $error("outputs active without input power");

  power_display_a: assert property (@(posedge clock) disable iff (!rst_n)
    !power_present |=> (stop_display == DISP_NONE))
    else $error("indication shown without input power");

  health_clean_a: assert property (@(posedge clock) disable iff (!rst_n)
    (power_present && !any_fault && !one_open) |=> health_reg)
    else $error("health off without an internal fault");

  monitor_fault_a: assert property (@(posedge clock) disable iff (!rst_n)
    (power_present && any_fault && both_open) |=> !monitor_terminal_on)
    else $error("stop monitor on during internal fault");

  display_code_a: assert property (@(posedge clock) disable iff (!rst_n)
    (power_present && fault_a_detect && !one_open) |=> (stop_display == DISP_FAULT_A))
    else $error("wrong fault code shown");

  run_default_a: assert property (@(posedge clock) disable iff (!rst_n)
    (sel_a_reg == CODE_RUN_POS) |=> (run_terminal_on == $past(map_bus.running)))
    else $error("run terminal does not follow running");

  // A clear in the same cycle must not swallow a new event
  event_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
    (|events) |=> ((irq_status_reg & $past(events)) == $past(events)))
    else $error("event lost in interrupt status");

endmodule

//--- dv/safety_relay_model.sv
module safety_relay_model (
  input wire logic clock,
  input wire logic open_a_req,
  input wire logic open_b_req,
  input wire logic run_req,
  input wire logic health_fb,
  output logic stop_input_a,
  output logic stop_input_b,
  output logic drive_running
);
  timeunit 1ns;
  timeprecision 1ns;
  // Contacts follow the request one edge late, like a relay
  always_ff @(posedge clock) begin
    stop_input_a <= !open_a_req;
    stop_input_b <= !open_b_req;
  end
  // Health gates drive_running at all times, never feeds a stop channel
  assign drive_running = run_req && health_fb;
endmodule

//--- dv/dual_channel_safety_stop_tb.sv
module dual_channel_safety_stop_tb;
  import safety_stop_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0;
  logic rst_n, power_present, open_a, open_b, fault_a_detect, fault_b_detect, run_req, cfg;
  logic stop_input_a, stop_input_b, drive_running, health_fb, pin_req;
  logic psel, penable, pwrite;
  logic [ADDR_WIDTH-1:0] paddr;
  logic [DATA_WIDTH-1:0] pwdata, prdata;
  logic pready, pslverr, drive_enable, monitor_terminal_on, irq;
  logic run_terminal_on, aux_terminal_b_on, aux_terminal_c_on;
  display_type stop_display;
  logic [CODE_WIDTH-1:0] code_a, code_b, code_c;
  logic [31:0] rnd;
  logic [32:0] got;
  logic [32:0] exp_q[$];
  int bad_count = 0;
  int num_checks = 0;
  logic [4:0] cases [10] = '{5'h10, 5'h12, 5'h11, 5'h13, 5'h1c, 5'h1d, 5'h1a, 5'h15, 5'h00,
    5'h10};

  always #5 clock = ~clock;
  // Before the terminals are remapped the feedback is held healthy
  assign health_fb = cfg ? run_terminal_on : 1'b1;

  dual_channel_safety_stop dual_channel_safety_stop_inst (.clock, .rst_n, .power_present,
    .stop_input_a, .stop_input_b, .fault_a_detect, .fault_b_detect, .drive_running, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .drive_enable,
    .monitor_terminal_on, .run_terminal_on, .aux_terminal_b_on, .aux_terminal_c_on,
    .stop_display, .irq);

  safety_relay_model safety_relay_model_inst (.clock, .open_a_req(open_a),
    .open_b_req(open_b), .run_req, .health_fb, .stop_input_a, .stop_input_b, .drive_running);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic term_val(input logic [7:0] code, input logic st, input logic h,
    input logic run);
    case (code)
      CODE_RUN_POS: return run;
      CODE_RUN_NEG: return !run;
      CODE_STOP_POS: return st;
      CODE_STOP_NEG: return !st;
      CODE_HEALTH_POS: return h;
      CODE_HEALTH_NEG: return !h;
      default: return 1'b0;
    endcase
  endfunction

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    if (!wr) exp_q.push_back(e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Case bits: power, open_a, open_b, fault_a, fault_b
  task automatic set_case(input logic [4:0] c, input logic irq_exp);
    logic r, flt, h, st, de, run;
    display_type d;
    r = rnd[0];
    rnd = lfsr(rnd);
    @(posedge clock);
    {power_present, open_a, open_b, fault_a_detect, fault_b_detect} <= c;
    run_req <= r;
    flt = c[1] | c[0];
    de = c[4] & !c[3] & !c[2] & !flt;
    h = c[4] & (c[3] == c[2]) & !flt;
    st = h & c[3] & c[2];
    d = (!c[4] || c[3] != c[2]) ? DISP_NONE : flt ? (c[1] ? DISP_FAULT_A : DISP_FAULT_B) :
      st ? DISP_STOP_ACTIVE : DISP_NONE;
    run = r & de;
    repeat (6) @(posedge clock);
    exp_q.push_back({25'h000_0000, de, st, term_val(code_a, st, h, run),
      term_val(code_b, st, h, run), term_val(code_c, st, h, run), irq_exp, d});
    pin_req <= 1'b1;
    @(posedge clock);
    pin_req <= 1'b0;
  endtask

  always @(posedge clock) begin
    if (pin_req || (psel && penable && pready && !pwrite)) begin
      got = pin_req ? {25'h000_0000, drive_enable, monitor_terminal_on, run_terminal_on,
        aux_terminal_b_on, aux_terminal_c_on, irq, stop_display} : {pslverr, prdata};
      num_checks++;
      if (exp_q.size() == 0 || got !== exp_q[0]) begin
        bad_count++;
        $display("FAIL %0t: expected %h got %h", $time, exp_q.size() ? exp_q[0] : 'x, got);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  initial begin
    #100us;
    bad_count++;
    give_verdict();
  end

  initial begin
    rnd = 32'h56e0_d42c;
    {rst_n, power_present, open_a, open_b, fault_a_detect, fault_b_detect} = 6'h10;
    {run_req, cfg, pin_req, psel, penable, pwrite} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    {code_a, code_b, code_c} = {SEL_A_RESET, SEL_B_RESET, SEL_C_RESET};
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_SEL_A, 32'h0000_0000, {9'h000, 16'h0000, SEL_A_RESET});
    apb(1'b0, 8'h40, 32'h0000_0000, {1'b1, 32'h0000_0000});
    set_case(5'h10, 1'b0);
    code_a = CODE_HEALTH_POS;
    for (int p = 0; p < 2; p++) begin
      code_b = p ? CODE_STOP_POS : CODE_STOP_NEG;
      code_c = p ? CODE_RUN_NEG : CODE_HEALTH_NEG;
      apb(1'b1, ADDR_SEL_A, {24'h00_0000, code_a}, 33'h0_0000_0000);
      apb(1'b1, ADDR_SEL_B, {24'h00_0000, code_b}, 33'h0_0000_0000);
      apb(1'b1, ADDR_SEL_C, {24'h00_0000, code_c}, 33'h0_0000_0000);
      cfg <= 1'b1;
      for (int i = 0; i < 10; i++) begin
        set_case(cases[i], 1'b0);
      end
    end
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0000_0000, 33'h0_0000_000f);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0001, 33'h0_0000_0000);
    set_case(5'h10, 1'b1);
    apb(1'b1, ADDR_IRQ_CLEAR, 32'h0000_000f, 33'h0_0000_0000);
    set_case(5'h10, 1'b0);
    set_case(5'h1c, 1'b1);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0000, 33'h0_0000_0000);
    set_case(5'h1c, 1'b0);
    // Stopped, stop indication, monitor and health on, all three terminals on
    apb(1'b0, ADDR_STATE, 32'h0000_0000, 33'h0_0007_0612);
    give_verdict();
  end
endmodule
